// ---- hdl/bbc_ctrl.sv ----
// I2C-reached control registers, reference update, discharge and protection sequencing
//
// What this block does
// - Go bit written one steps reference to target, then self-clears on arrival.
// - Go bit reads one during scaling, zero once scaling is finished.
// - Discharge path is on while go is one, regardless of discharge control.
// - Discharge stays on 20 ms after go clears, then releases.
// - Switching enable gates power switching and the delayed off-state discharge; resets to zero.
// - After switching enable clears, discharge becomes effective only after 200 ms.
// - Two-bit frequency field picks 200/300/400/600 kHz, resets to 10, always writable.
// - Frequency rewrites move gradually to the new frequency.
// - Buck-boost region bit picks 62.5 or 37.5 percent of base; resets zero.
// - Over-current action 00 uses only cycle-by-cycle limit.
// - Over-current action 01 hiccups on limit with feedback below 60 percent.
// - Over-current action 10 latches off until enable cycled or re-power.
// - Over-voltage action 00 takes no action, no discharge.
// - Over-voltage action 01 stops switching, discharges above 127, resumes at 111.
// - Over-voltage action 10 latches off without discharge.
`timescale 1ns/1ps
`include "bbc_map.svh"

module bbc_ctrl #(
  parameter logic [6:0] DEV_ADDR      = 7'h60,
  parameter int         POST_GO_CYC   = `BBC_MS_TO_CYC(`BBC_POST_GO_MS),
  parameter int         OFF_DELAY_CYC = `BBC_MS_TO_CYC(`BBC_OFF_DELAY_MS),
  parameter int         FREQ_STEP_CYC = `BBC_NS_TO_CYC(`BBC_FREQ_STEP_NS)
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output wire logic                  sda_out,
  output wire logic                  sda_oe,
  input  wire logic                  ref_at_target,
  input  wire logic                  ilim_trip,
  input  wire logic                  fb_below_60,
  input  wire logic                  fb_above_127,
  input  wire logic                  fb_below_111,
  input  wire logic                  ss_discharged,
  output wire logic                  ref_ramp_en,
  output wire logic                  power_switch_en,
  output wire logic                  discharge_on,
  output wire logic                  ss_discharge,
  output wire logic [`BBC_KHZ_W-1:0] base_freq_khz,
  output wire logic [`BBC_KHZ_W-1:0] bb_freq_khz,
  output wire logic [7:0]            ctrl_one_q,
  output wire logic [7:0]            ctrl_two_q
);

  localparam int CMP_REF  = 0;
  localparam int CMP_ILIM = 1;
  localparam int CMP_FB60 = 2;
  localparam int CMP_OV   = 3;
  localparam int CMP_REC  = 4;
  localparam int CMP_SS   = 5;

  bbc_pkg::bbc_state_s state_r;
  bbc_pkg::bbc_state_s state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [`BBC_KHZ_W-1:0] bbc_fsw_khz(input logic [1:0] code);
    case (code)
      2'h0:    bbc_fsw_khz = 10'd200;
      2'h1:    bbc_fsw_khz = 10'd300;
      2'h2:    bbc_fsw_khz = 10'd400;
      default: bbc_fsw_khz = 10'd600;
    endcase
  endfunction : bbc_fsw_khz

  // Reserved code behaves as the reset setting
  function automatic logic [1:0] bbc_action(input logic [1:0] code);
    bbc_action = (code == 2'h3) ? `BBC_ACT_AUTO : code;
  endfunction : bbc_action

  function automatic logic [7:0] bbc_read(input logic [7:0] addr,
                                          input logic [7:0] c1,
                                          input logic [7:0] c2);
    if (addr == `BBC_REG_CTRL_ONE)
      bbc_read = c1;
    else if (addr == `BBC_REG_CTRL_TWO)
      bbc_read = c2;
    else
      bbc_read = 8'h00;
  endfunction : bbc_read

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic                  scl_rise;
  logic                  scl_fall;
  logic                  i2c_start;
  logic                  i2c_stop;
  logic                  wr_stb;
  logic [7:0]            rd_byte;
  logic [1:0]            overcurrent_action;
  logic [1:0]            overvoltage_action;
  logic                  en_now;
  logic                  go_now;
  logic                  dis_ok;
  logic [`BBC_KHZ_W-1:0] target_khz;
  logic [`BBC_KHZ_W+2:0] bb_prod;

  always_comb
  begin
    state_nxt = state_r;
    wr_stb    = 1'b0;
    rd_byte   = 8'h00;

    // Pins and comparator flags: second flop only reads the first
    state_nxt.scl_s1 = scl_in;
    state_nxt.scl_s2 = state_r.scl_s1;
    state_nxt.scl_d  = state_r.scl_s2;
    state_nxt.sda_s1 = sda_in;
    state_nxt.sda_s2 = state_r.sda_s1;
    state_nxt.sda_d  = state_r.sda_s2;
    state_nxt.cmp_s1 = {ss_discharged, fb_below_111, fb_above_127,
                        fb_below_60, ilim_trip, ref_at_target};
    state_nxt.cmp_s2 = state_r.cmp_s1;

    scl_rise  = state_r.scl_s2 & ~state_r.scl_d;
    scl_fall  = ~state_r.scl_s2 & state_r.scl_d;
    i2c_start = state_r.scl_s2 & state_r.scl_d & state_r.sda_d & ~state_r.sda_s2;
    i2c_stop  = state_r.scl_s2 & state_r.scl_d & ~state_r.sda_d & state_r.sda_s2;

    // I2C target: sample on SCL rise, drive on SCL fall
    if (i2c_start)
    begin
      state_nxt.st     = bbc_pkg::BBC_ADDR;
      state_nxt.cnt    = 3'h0;
      state_nxt.got8   = 1'b0;
      state_nxt.sda_oe = 1'b0;
    end
    else if (i2c_stop)
    begin
      state_nxt.st     = bbc_pkg::BBC_IDLE;
      state_nxt.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (state_r.st)
        bbc_pkg::BBC_ADDR, bbc_pkg::BBC_REG, bbc_pkg::BBC_WDATA:
        begin
          state_nxt.sh   = {state_r.sh[6:0], state_r.sda_s2};
          state_nxt.cnt  = state_r.cnt + 3'h1;
          state_nxt.got8 = (state_r.cnt == 3'h7);
        end
        bbc_pkg::BBC_RDATA:
        begin
          state_nxt.cnt  = state_r.cnt + 3'h1;
          state_nxt.got8 = (state_r.cnt == 3'h7);
        end
        bbc_pkg::BBC_RACK:
          state_nxt.nack = state_r.sda_s2;
        default:
          state_nxt.nack = state_r.nack;
      endcase
    end
    else if (scl_fall)
    begin
      state_nxt.got8 = 1'b0;
      rd_byte        = bbc_read(state_r.ptr, state_r.ctrl_one, state_r.ctrl_two);
      case (state_r.st)
        bbc_pkg::BBC_ADDR:
          if (state_r.got8)
          begin
            if (state_r.sh[7:1] == DEV_ADDR)
            begin
              state_nxt.st     = bbc_pkg::BBC_ACK_A;
              state_nxt.rw     = state_r.sh[0];
              state_nxt.sda_oe = 1'b1;
            end
            else
              state_nxt.st = bbc_pkg::BBC_IDLE;
          end
        bbc_pkg::BBC_ACK_A:
        begin
          state_nxt.cnt = 3'h0;
          if (state_r.rw)
          begin
            state_nxt.st     = bbc_pkg::BBC_RDATA;
            state_nxt.sh     = rd_byte;
            state_nxt.sda_oe = ~rd_byte[7];
            state_nxt.ptr    = state_r.ptr + 8'h01;
          end
          else
          begin
            state_nxt.st     = bbc_pkg::BBC_REG;
            state_nxt.sda_oe = 1'b0;
          end
        end
        bbc_pkg::BBC_REG:
          if (state_r.got8)
          begin
            state_nxt.ptr    = state_r.sh;
            state_nxt.st     = bbc_pkg::BBC_ACK_R;
            state_nxt.sda_oe = 1'b1;
          end
        bbc_pkg::BBC_ACK_R, bbc_pkg::BBC_ACK_W:
        begin
          state_nxt.st     = bbc_pkg::BBC_WDATA;
          state_nxt.cnt    = 3'h0;
          state_nxt.sda_oe = 1'b0;
        end
        bbc_pkg::BBC_WDATA:
          if (state_r.got8)
          begin
            wr_stb           = 1'b1;
            state_nxt.ptr    = state_r.ptr + 8'h01;
            state_nxt.st     = bbc_pkg::BBC_ACK_W;
            state_nxt.sda_oe = 1'b1;
          end
        bbc_pkg::BBC_RDATA:
          if (state_r.got8)
          begin
            state_nxt.st     = bbc_pkg::BBC_RACK;
            state_nxt.sda_oe = 1'b0;
          end
          else
          begin
            state_nxt.sh     = {state_r.sh[6:0], 1'b0};
            state_nxt.sda_oe = ~state_r.sh[6];
          end
        bbc_pkg::BBC_RACK:
          if (state_r.nack)
            state_nxt.st = bbc_pkg::BBC_IDLE;
          else
          begin
            state_nxt.st     = bbc_pkg::BBC_RDATA;
            state_nxt.cnt    = 3'h0;
            state_nxt.sh     = rd_byte;
            state_nxt.sda_oe = ~rd_byte[7];
            state_nxt.ptr    = state_r.ptr + 8'h01;
          end
        default:
          state_nxt.sda_oe = 1'b0;
      endcase
    end

    // Go clears on arrival; a write in the same cycle wins
    if (state_r.ctrl_one[`BBC_C1_GO] && state_r.cmp_s2[CMP_REF])
      state_nxt.ctrl_one[`BBC_C1_GO] = 1'b0;
    if (wr_stb && state_r.ptr == `BBC_REG_CTRL_ONE)
      state_nxt.ctrl_one = state_r.sh;
    if (wr_stb && state_r.ptr == `BBC_REG_CTRL_TWO)
      state_nxt.ctrl_two = state_r.sh & `BBC_CTRL_TWO_WMASK;

    en_now   = state_r.ctrl_one[`BBC_C1_EN];
    go_now   = state_r.ctrl_one[`BBC_C1_GO];
    overcurrent_action = bbc_action(state_r.ctrl_two[`BBC_C2_OCP_LSB+:2]);
    overvoltage_action = bbc_action(state_r.ctrl_two[`BBC_C2_OVP_LSB+:2]);
    state_nxt.ramp_en = state_nxt.ctrl_one[`BBC_C1_GO];

    // Hold discharge after go falls
    if (go_now && !state_nxt.ctrl_one[`BBC_C1_GO])
      state_nxt.post_cnt = `BBC_CNT_W'(POST_GO_CYC);
    else if (state_r.post_cnt != '0)
      state_nxt.post_cnt = state_r.post_cnt - `BBC_CNT_W'(1);

    // Disable delay before the off-state discharge becomes effective
    if (en_now)
      state_nxt.off_cnt = '0;
    else if (state_r.off_cnt != `BBC_CNT_W'(OFF_DELAY_CYC))
      state_nxt.off_cnt = state_r.off_cnt + `BBC_CNT_W'(1);
    dis_ok = !en_now && (state_r.off_cnt == `BBC_CNT_W'(OFF_DELAY_CYC));

    // Over-current handling
    if (!en_now || overcurrent_action != `BBC_ACT_AUTO)
      state_nxt.hiccup = 1'b0;
    else if (state_r.cmp_s2[CMP_ILIM] && state_r.cmp_s2[CMP_FB60])
      state_nxt.hiccup = 1'b1;
    else if (state_r.hiccup && state_r.cmp_s2[CMP_SS])
      state_nxt.hiccup = 1'b0;
    if (!en_now)
      state_nxt.ocp_lat = 1'b0;
    else if (overcurrent_action == `BBC_ACT_LATCH && state_r.cmp_s2[CMP_ILIM])
      state_nxt.ocp_lat = 1'b1;
    state_nxt.ss_dis = state_nxt.hiccup;

    // Over-voltage handling; trip keeps hysteresis between 127 and 111
    if (overvoltage_action != `BBC_ACT_AUTO)
      state_nxt.ovp_trip = 1'b0;
    else if (state_r.cmp_s2[CMP_OV])
      state_nxt.ovp_trip = 1'b1;
    else if (state_r.cmp_s2[CMP_REC])
      state_nxt.ovp_trip = 1'b0;
    if (!en_now)
      state_nxt.ovp_lat = 1'b0;
    else if (overvoltage_action == `BBC_ACT_LATCH && state_r.cmp_s2[CMP_OV])
      state_nxt.ovp_lat = 1'b1;

    // Only the switching stage stops; everything else keeps running
    state_nxt.sw_en = en_now && !state_nxt.hiccup && !state_nxt.ocp_lat &&
                      !state_nxt.ovp_trip && !state_nxt.ovp_lat;
    state_nxt.dis_on = go_now || (state_r.post_cnt != '0) || state_nxt.ovp_trip ||
                       (dis_ok && state_r.ctrl_one[`BBC_C1_DIS_FORCE]);

    // Frequency glides one kHz per step toward the selected value
    target_khz = bbc_fsw_khz(state_r.ctrl_two[`BBC_C2_FSW_LSB+:2]);
    if (state_r.freq_khz == target_khz)
      state_nxt.step_cnt = '0;
    else if (state_r.step_cnt + 16'h0001 >= 16'(FREQ_STEP_CYC))
    begin
      state_nxt.step_cnt = '0;
      if (state_r.freq_khz < target_khz)
        state_nxt.freq_khz = state_r.freq_khz + `BBC_KHZ_W'(1);
      else
        state_nxt.freq_khz = state_r.freq_khz - `BBC_KHZ_W'(1);
    end
    else
      state_nxt.step_cnt = state_r.step_cnt + 16'h0001;

    // Five or three eighths of the base
    bb_prod = state_r.ctrl_two[`BBC_C2_BB_SEL] ?
              {3'h0, state_r.freq_khz} * 13'd5 :
              {3'h0, state_r.freq_khz} * 13'd3;
    state_nxt.bb_khz = bb_prod[`BBC_KHZ_W+2:3];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r          <= '0;
      state_r.st       <= bbc_pkg::BBC_IDLE;
      state_r.scl_s1   <= 1'b1;
      state_r.scl_s2   <= 1'b1;
      state_r.scl_d    <= 1'b1;
      state_r.sda_s1   <= 1'b1;
      state_r.sda_s2   <= 1'b1;
      state_r.sda_d    <= 1'b1;
      state_r.ctrl_one <= `BBC_CTRL_ONE_RST;
      state_r.ctrl_two <= `BBC_CTRL_TWO_RST;
      state_r.freq_khz <= 10'd400;
      state_r.bb_khz   <= 10'd150;
    end
    else
      state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state flops except sda_out, which is tied low

  assign sda_out         = 1'b0;
  assign sda_oe          = state_r.sda_oe;
  assign ref_ramp_en     = state_r.ramp_en;
  assign power_switch_en = state_r.sw_en;
  assign discharge_on    = state_r.dis_on;
  assign ss_discharge    = state_r.ss_dis;
  assign base_freq_khz   = state_r.freq_khz;
  assign bb_freq_khz     = state_r.bb_khz;
  assign ctrl_one_q      = state_r.ctrl_one;
  assign ctrl_two_q      = state_r.ctrl_two;

endmodule : bbc_ctrl

// ---- common/bbc_map.svh ----
// Register map, field positions, reset values and timing for the buck-boost control block
`ifndef BBC_MAP_SVH
`define BBC_MAP_SVH

`define BBC_REG_CTRL_ONE     8'h02
`define BBC_REG_CTRL_TWO     8'h03
`define BBC_CTRL_ONE_RST     8'h40
`define BBC_CTRL_TWO_RST     8'h85
`define BBC_CTRL_TWO_WMASK   8'hDF

`define BBC_C1_EN            0
`define BBC_C1_GO            1
`define BBC_C1_DIS_FORCE     5
`define BBC_C2_OVP_LSB       0
`define BBC_C2_OCP_LSB       2
`define BBC_C2_BB_SEL        4
`define BBC_C2_FSW_LSB       6

`define BBC_ACT_NONE         2'h0
`define BBC_ACT_AUTO         2'h1
`define BBC_ACT_LATCH        2'h2

`define BBC_CLK_PERIOD_NS    10
`define BBC_POST_GO_MS       20
`define BBC_OFF_DELAY_MS     200
`define BBC_FREQ_STEP_NS     1000
`define BBC_MS_TO_CYC(ms)    (((ms) * 1000000 + `BBC_CLK_PERIOD_NS - 1) / `BBC_CLK_PERIOD_NS)
`define BBC_NS_TO_CYC(ns)    (((ns) + `BBC_CLK_PERIOD_NS - 1) / `BBC_CLK_PERIOD_NS)

`define BBC_CNT_W            25
`define BBC_KHZ_W            10
`define BBC_CMP_W            6

`endif

// ---- common/bbc_pkg.sv ----
// Types shared by the buck-boost control block
`include "bbc_map.svh"

package bbc_pkg;

  typedef enum logic [3:0] {
    BBC_IDLE, BBC_ADDR, BBC_ACK_A, BBC_REG, BBC_ACK_R,
    BBC_WDATA, BBC_ACK_W, BBC_RDATA, BBC_RACK
  } bbc_i2c_e;

  typedef struct packed {
    bbc_i2c_e                st;
    logic                    scl_s1;
    logic                    scl_s2;
    logic                    scl_d;
    logic                    sda_s1;
    logic                    sda_s2;
    logic                    sda_d;
    logic [2:0]              cnt;
    logic                    got8;
    logic                    rw;
    logic                    nack;
    logic [7:0]              sh;
    logic [7:0]              ptr;
    logic                    sda_oe;
    logic [7:0]              ctrl_one;
    logic [7:0]              ctrl_two;
    logic [`BBC_CNT_W-1:0]   post_cnt;
    logic [`BBC_CNT_W-1:0]   off_cnt;
    logic [15:0]             step_cnt;
    logic [`BBC_KHZ_W-1:0]   freq_khz;
    logic [`BBC_KHZ_W-1:0]   bb_khz;
    logic [`BBC_CMP_W-1:0]   cmp_s1;
    logic [`BBC_CMP_W-1:0]   cmp_s2;
    logic                    hiccup;
    logic                    ocp_lat;
    logic                    ovp_trip;
    logic                    ovp_lat;
    logic                    sw_en;
    logic                    dis_on;
    logic                    ss_dis;
    logic                    ramp_en;
  } bbc_state_s;

endpackage : bbc_pkg

// ---- dv/bbc_host.sv ----
// Host-side I2C master model for the control block
`timescale 1ns/1ps

module bbc_host #(
  parameter logic [6:0] ADDR = 7'h60
) (
  input  wire logic clk_sys,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_pull
);
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Phase of 12 core cycles keeps both SCL phases far above the minimum
  task automatic hp();
    repeat (12) @(negedge clk_sys);
  endtask : hp

  task automatic bt(input logic b, output logic r);
    sda_pull = ~b;
    hp();
    scl = 1'b1;
    hp();
    r   = sda_w;
    scl = 1'b0;
    hp();
  endtask : bt

  // Start and repeated start alike
  task automatic st();
    sda_pull = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_pull = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask : st

  task automatic sp();
    sda_pull = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_pull = 1'b0;
    hp();
  endtask : sp

  task automatic tx(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--)
      bt(d[i], r);
    bt(1'b1, nak);
  endtask : tx

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic n;
    st();
    tx({ADDR, 1'b0}, n);
    tx(a, n);
    tx(d, n);
    sp();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic n;
    st();
    tx({ADDR, 1'b0}, n);
    tx(a, n);
    st();
    tx({ADDR, 1'b1}, n);
    for (int i = 7; i >= 0; i--)
      bt(1'b1, d[i]);
    bt(1'b1, n);
    sp();
  endtask : rd
endmodule : bbc_host

// ---- dv/bbc_ctrl_assertions.sv ----
// Port-level assertions for the buck-boost control block
`timescale 1ns/1ps
`include "bbc_map.svh"

module bbc_ctrl_assertions #(
  parameter int POST_GO_CYC = 50
) (
  input wire logic                  clk_sys,
  input wire logic                  reset_n,
  input wire logic                  ref_at_target,
  input wire logic                  ilim_trip,
  input wire logic                  fb_below_60,
  input wire logic                  fb_above_127,
  input wire logic                  ref_ramp_en,
  input wire logic                  power_switch_en,
  input wire logic                  discharge_on,
  input wire logic                  ss_discharge,
  input wire logic [`BBC_KHZ_W-1:0] base_freq_khz,
  input wire logic [`BBC_KHZ_W-1:0] bb_freq_khz,
  input wire logic [7:0]            ctrl_one_q,
  input wire logic [7:0]            ctrl_two_q
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  localparam int GO_SAT = POST_GO_CYC + 3;
  int go_gap_r;

  function automatic logic [`BBC_KHZ_W-1:0] bb_of(input logic s, input logic [9:0] f);
    logic [12:0] p;
    p = {3'h0, f} * (s ? 13'h0005 : 13'h0003);
    return p[12:3];
  endfunction : bb_of

  // Cycles since go was last high, saturating so reset never looks like a fresh fall
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      go_gap_r <= GO_SAT;
    else if (ctrl_one_q[`BBC_C1_GO])
      go_gap_r <= 0;
    else if (go_gap_r < GO_SAT)
      go_gap_r <= go_gap_r + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp enable and go are registered on the same edge
  chk_ramp_follow: assert property (ref_ramp_en == ctrl_one_q[1])
    else $error("ramp enable does not follow go");
  // Two sync flops plus one register stage: third sample with target seen clears go
  chk_go_clear: assert property ((ctrl_one_q[1] && ref_at_target)[*3] |=> !ctrl_one_q[1])
    else $error("go not cleared at target");
  chk_go_dis: assert property (ctrl_one_q[1] && $past(ctrl_one_q[1]) |-> discharge_on)
    else $error("discharge off while go set");
  chk_hold_dis: assert property (
    !ctrl_one_q[1] && go_gap_r inside {[1:POST_GO_CYC-2]} |-> discharge_on)
    else $error("discharge released early");
  chk_sw_off: assert property (!ctrl_one_q[0] && !$past(ctrl_one_q[0]) |-> !power_switch_en)
    else $error("switching while disabled");
  chk_no_prot: assert property (
    !ctrl_one_q[0] ##1 (ctrl_one_q[0] && ctrl_two_q[3:0] == 4'h0)[*6] |-> power_switch_en)
    else $error("switching held off without protection");
  chk_freq_step: assert property (
    $changed(base_freq_khz) |-> (base_freq_khz == $past(base_freq_khz) + 1 ||
    base_freq_khz + 1 == $past(base_freq_khz)) ##1 $stable(base_freq_khz))
    else $error("frequency jumped");
  chk_freq_goal: assert property (
    ($stable(base_freq_khz) && $stable(ctrl_two_q[7:6]))[*8] |->
    base_freq_khz == (ctrl_two_q[7:6] == 2'h3 ? 10'h258 : 10'h0C8 + 10'h064 * ctrl_two_q[7:6]))
    else $error("frequency settled off target");
  chk_bb_ratio: assert property (
    $stable(ctrl_two_q[4]) |-> bb_freq_khz == $past(bb_of(ctrl_two_q[4], base_freq_khz)))
    else $error("buck-boost frequency ratio wrong");
  chk_ovp_auto: assert property (
    (ctrl_two_q[0] && fb_above_127)[*5] |-> discharge_on && !power_switch_en)
    else $error("over-voltage auto response missing");
  chk_ocp_hiccup: assert property (
    (ctrl_two_q[2] && ctrl_one_q[0] && ilim_trip && fb_below_60)[*5] |->
    ss_discharge && !power_switch_en)
    else $error("hiccup not entered");
  chk_ocp_latch: assert property (
    (ctrl_two_q[3:2] == `BBC_ACT_LATCH && ctrl_one_q[0] && ilim_trip)[*5] ##1
    ctrl_one_q[0][*8] |-> !power_switch_en)
    else $error("over-current latch released");
endmodule : bbc_ctrl_assertions

bind bbc_ctrl bbc_ctrl_assertions #(.POST_GO_CYC(POST_GO_CYC)) chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .ref_at_target(ref_at_target), .ilim_trip(ilim_trip),
  .fb_below_60(fb_below_60), .fb_above_127(fb_above_127), .ref_ramp_en(ref_ramp_en),
  .power_switch_en(power_switch_en), .discharge_on(discharge_on), .ss_discharge(ss_discharge),
  .base_freq_khz(base_freq_khz), .bb_freq_khz(bb_freq_khz), .ctrl_one_q(ctrl_one_q),
  .ctrl_two_q(ctrl_two_q));

// ---- dv/bbc_ctrl_bench.sv ----
// Self-checking bench for the buck-boost control block
`timescale 1ns/1ps
`include "bbc_map.svh"

module bbc_ctrl_bench;
  localparam int POST = 50;
  localparam int OFFD = 100;
  logic                  clk_sys, reset_n, scl, pull, sda_oe, sda_out, nak;
  logic                  ref_at, ilim, fb60, fb127, fb111, ss_done, ramp, sw_en, dis, ss_dis;
  logic [`BBC_KHZ_W-1:0] base, bbf;
  logic [7:0]            c1, c2, rd, v;
  wire logic             sda_w;
  int                    n_fail = 0;
  int                    n_compared = 0;
  int                    cyc = 0;

  // Open-drain wire with pull-up
  assign sda_w = ~((sda_oe & ~sda_out) | pull);

  bbc_ctrl #(.POST_GO_CYC(POST), .OFF_DELAY_CYC(OFFD), .FREQ_STEP_CYC(2)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .ref_at_target(ref_at), .ilim_trip(ilim), .fb_below_60(fb60),
    .fb_above_127(fb127), .fb_below_111(fb111), .ss_discharged(ss_done), .ref_ramp_en(ramp),
    .power_switch_en(sw_en), .discharge_on(dis), .ss_discharge(ss_dis), .base_freq_khz(base),
    .bb_freq_khz(bbf), .ctrl_one_q(c1), .ctrl_two_q(c2));

  bbc_host host_u (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl), .sda_pull(pull));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({15'h0000, got}, {15'h0000, exp});
  endtask : cmp_bit

  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt

  function automatic logic [15:0] khz(input int s);
    return (s == 3) ? 16'h0258 : 16'h00C8 + 16'h0064 * s[1:0];
  endfunction : khz

  function automatic logic [15:0] bbk(input logic s, input logic [15:0] f);
    return (f * (s ? 16'h0005 : 16'h0003)) >> 3;
  endfunction : bbk

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {ref_at, ilim, fb60, fb127, ss_done} = 5'h00;
    fb111   = 1'b1;
    reset_n = 1'b0;
    void'($urandom(15085));
    wt(6);
    reset_n = 1'b1;
    wt(6);
    cmp_val(16'(base), 16'h0190);
    cmp_val(16'(bbf), 16'h0096);
    host_u.rd(`BBC_REG_CTRL_ONE, rd);
    cmp_val(16'(rd), 16'(`BBC_CTRL_ONE_RST));
    host_u.rd(`BBC_REG_CTRL_TWO, rd);
    cmp_val(16'(rd), 16'(`BBC_CTRL_TWO_RST));
    host_u.rd(8'h07, rd);
    cmp_val(16'(rd), 16'h0000);
    host_u.st();
    host_u.tx(8'hA0, nak);
    host_u.sp();
    cmp_bit(nak, 1'b1);
    $display("reset and map test done");
    // Start-up: reference update with switching off, then enable
    host_u.wr(`BBC_REG_CTRL_TWO, 8'h80);
    host_u.wr(`BBC_REG_CTRL_ONE, 8'h44);
    host_u.wr(`BBC_REG_CTRL_ONE, 8'h46);
    wt(2);
    cmp_bit(ramp, 1'b1);
    cmp_bit(dis, 1'b1);
    host_u.rd(`BBC_REG_CTRL_ONE, rd);
    cmp_val(16'(rd), 16'h0046);
    ref_at = 1'b1;
    wt(5);
    cmp_bit(c1[1], 1'b0);
    wt(POST - 8);
    cmp_bit(dis, 1'b1);
    wt(12);
    cmp_bit(dis, 1'b0);
    ref_at = 1'b0;
    host_u.rd(`BBC_REG_CTRL_ONE, rd);
    cmp_val(16'(rd), 16'h0044);
    wt(OFFD);
    host_u.wr(`BBC_REG_CTRL_ONE, 8'h45);
    wt(6);
    cmp_bit(sw_en, 1'b1);
    $display("go test done");
    for (int i = 0; i < 4; i++)
    begin
      // Ratio bit alternates so both buck-boost ratios are seen
      v = {i[1:0], 1'($urandom), i[0], 4'($urandom)};
      host_u.wr(`BBC_REG_CTRL_TWO, v);
      host_u.rd(`BBC_REG_CTRL_TWO, rd);
      cmp_val(16'(rd), 16'(v & `BBC_CTRL_TWO_WMASK));
      cmp_val(16'(c2), 16'(v & `BBC_CTRL_TWO_WMASK));
      for (int t = 0; t < 1000 && 16'(base) !== khz(i); t++)
        wt(1);
      cmp_val(16'(base), khz(i));
      wt(2);
      cmp_val(16'(bbf), bbk(v[4], khz(i)));
    end
    $display("frequency test done");
    // Discharge force only after the off delay
    host_u.wr(`BBC_REG_CTRL_ONE, 8'h64);
    wt(6);
    cmp_bit(sw_en, 1'b0);
    cmp_bit(dis, 1'b0);
    wt(OFFD);
    cmp_bit(dis, 1'b1);
    host_u.wr(`BBC_REG_CTRL_ONE, 8'h44);
    $display("off delay test done");
    for (int k = 0; k < 2; k++)
      for (int m = 0; m < 4; m++)
      begin
        v = 8'h80 | 8'(k ? m : m * 4);
        host_u.wr(`BBC_REG_CTRL_TWO, v);
        host_u.wr(`BBC_REG_CTRL_ONE, 8'h45);
        if (k)
          {fb127, fb111} = 2'b10;
        else
          {ilim, fb60} = 2'b11;
        wt(20);
        cmp_bit(sw_en, m == 0);
        cmp_bit(ss_dis, !k && m[0]);
        cmp_bit(dis, k && m[0]);
        {ilim, fb60, fb127, fb111, ss_done} = 5'h03;
        wt(20);
        cmp_bit(sw_en, m != 2);
        cmp_bit(dis, 1'b0);
        ss_done = 1'b0;
        host_u.wr(`BBC_REG_CTRL_ONE, 8'h44);
        $display("protection test kind %0d mode %0d done", k, m);
      end
    // Mid-run reset with the bus idle brings back the reset values
    reset_n = 1'b0;
    wt(2);
    reset_n = 1'b1;
    wt(6);
    cmp_val(16'(c1), 16'(`BBC_CTRL_ONE_RST));
    cmp_val(16'(c2), 16'(`BBC_CTRL_TWO_RST));
    cmp_bit(sw_en, 1'b0);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule : bbc_ctrl_bench
